// >>> psii_pkg.sv
package psii_pkg;
	localparam int CLK_HZ = 200_000_000;
	localparam int CHAR_RATE_HZ = 500_000;
	localparam int CHAR_CYCLES = CLK_HZ / CHAR_RATE_HZ;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int NUM_LEVELS = 4;
	localparam int DEV_SPACE_BYTES = 1024;
	localparam int SER_SPACE_BYTES = 256;
	localparam logic [ADDR_W-1:0] DEV_SPACE_BASE = ADDR_W'(65536 - DEV_SPACE_BYTES);
	localparam logic [ADDR_W-1:0] SER_SPACE_BASE = ADDR_W'(65536 - SER_SPACE_BYTES);
	localparam logic [ADDR_W-1:0] OFS_STATUS = 16'h0000;
	localparam logic [ADDR_W-1:0] OFS_INBUF = 16'h0002;
	localparam logic [ADDR_W-1:0] OFS_OUTBUF = 16'h0004;
	localparam logic [ADDR_W-1:0] OFS_SPAN = 16'h0006;
	localparam int ST_IE = 0;
	localparam int ST_FUNC = 1;
	localparam int ST_UNIT_LO = 2;
	localparam int UNIT_W = 2;
	localparam int ST_IRQ = 4;
	localparam int ST_IN_DONE = 5;
	localparam int ST_ERR = 6;
	localparam int ST_OUT_DONE = 7;
	localparam logic [1:0] LVL_SERIAL = 2'h0;
	localparam logic [1:0] LVL_PAR_MIN = 2'h1;
	localparam logic [11:0] APB_CMD = 12'h000;
	localparam logic [11:0] APB_WDATA = 12'h004;
	localparam logic [11:0] APB_RESULT = 12'h008;
	localparam logic [11:0] APB_IRQ_STATUS = 12'h00C;
	localparam logic [11:0] APB_IRQ_CLEAR = 12'h010;
	localparam logic [11:0] APB_IRQ_ENABLE = 12'h014;
	localparam logic [11:0] APB_VECTOR = 12'h018;
	localparam logic [11:0] APB_POLL_CTRL = 12'h01C;
	localparam int CMD_WR = 16;
	localparam int CMD_BYTE = 17;
	localparam int RES_BUSY = 16;
	localparam int RES_NOACK = 17;
	localparam int EV_XFER = 0;
	localparam int EV_VECTOR = 1;
	localparam int NUM_EV = 2;
	localparam int NOACK_CYCLES = 64;
	function automatic logic inSpace(input logic [ADDR_W-1:0] a, input logic serial);
		return serial ? (a >= SER_SPACE_BASE) : (a >= DEV_SPACE_BASE && a < SER_SPACE_BASE);
	endfunction
endpackage

// >>> psii_io_if.sv
`timescale 1ns/1ps
interface psii_io_if (
	input wire logic clock,
	input wire logic pollChainIn
);
	import psii_pkg::*;
	logic ioReq;
	logic ioWr;
	logic ioByte;
	logic [ADDR_W-1:0] ioAddr;
	logic [DATA_W-1:0] ioWdata;
	logic [DATA_W-1:0] ioRdata;
	logic ioAck;
	logic [NUM_LEVELS-1:0] reqLevel;
	logic pollReq;
	logic [1:0] pollLevel;
	logic pollAck;
	logic pollChainOut;
	modport dev (
		input ioReq, ioWr, ioByte, ioAddr, ioWdata, pollReq, pollLevel, pollChainIn,
		output ioRdata, ioAck, reqLevel, pollAck, pollChainOut
	);
	modport host (
		output ioReq, ioWr, ioByte, ioAddr, ioWdata, pollReq, pollLevel,
		input ioRdata, ioAck, reqLevel, pollAck
	);
endinterface

// >>> psii_char_pacer.sv
`timescale 1ns/1ps
module psii_char_pacer
	import psii_pkg::*;
#(
	parameter int CYCLES = CHAR_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic run,
	output logic tick
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
	logic [CW-1:0] count_q;
	logic [CW-1:0] count_d;

	always_comb begin
		tick = run && (count_q == LAST);
		count_d = (!run || tick) ? '0 : count_q + CW'(1);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end
endmodule

// >>> psii_device.sv
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module psii_device
	import psii_pkg::*;
#(
	parameter logic [ADDR_W-1:0] BASE_ADDR = 16'hFFF0,
	parameter bit SERIAL = 1'b1,
	parameter logic [1:0] LEVEL = LVL_SERIAL,
	parameter logic [DATA_W-1:0] VECTOR = 16'h0040,
	parameter int CHAR_PERIOD = CHAR_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	psii_io_if.dev io,
	output logic [7:0] txData,
	output logic txStrobe,
	input wire logic rxValid,
	input wire logic [7:0] rxData,
	input wire logic periphError,
	output logic [UNIT_W-1:0] unitSel,
	output logic irqPending
);
	// level and vector come from parameters only; nothing in software can move them
	localparam logic [1:0] EFF_LEVEL = SERIAL ? LVL_SERIAL :
		((LEVEL == LVL_SERIAL) ? LVL_PAR_MIN : LEVEL);

	logic ie_q, ie_d;
	logic [UNIT_W-1:0] unit_q, unit_d;
	logic irqReq_q, irqReq_d;
	logic inDone_q, inDone_d;
	logic err_q, err_d;
	logic outDone_q, outDone_d;
	logic [7:0] inBuf_q, inBuf_d;
	logic [7:0] outBuf_q, outBuf_d;
	logic [7:0] txData_q, txData_d;
	logic txStrobe_q, txStrobe_d;
	logic [2:0] flagsPrev_q, flagsPrev_d;
	logic ack_q, ack_d;
	logic pollAck_q, pollAck_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic [9:0] pinMeta_q, pinMeta_d;
	logic [9:0] pinSync_q, pinSync_d;
	logic rxValidS;
	logic periphErrorS;
	logic [7:0] rxDataS;

	typedef enum logic [1:0] {
		OUT_IDLE = 2'b01,
		OUT_BUSY = 2'b10
	} psii_out_t;
	psii_out_t outState_q, outState_d;

	logic tick;
	logic hit;
	logic [ADDR_W-1:0] offset;
	logic [DATA_W-1:0] statusWord;
	logic [2:0] flagsNow;
	logic [2:0] rise;
	logic pollMine;

	function automatic logic isReg(input logic [ADDR_W-1:0] ofs, input logic [ADDR_W-1:0] reg_ofs);
		return ofs[ADDR_W-1:1] == reg_ofs[ADDR_W-1:1];
	endfunction

	psii_char_pacer #(
		.CYCLES(CHAR_PERIOD)
	) pacer (
		.clock(clock),
		.rst(rst),
		.run(outState_q == OUT_BUSY),
		.tick(tick)
	);

	always_comb begin
		statusWord = '0;
		statusWord[ST_IE] = ie_q;
		statusWord[ST_UNIT_LO +: UNIT_W] = unit_q;
		statusWord[ST_IRQ] = irqReq_q;
		statusWord[ST_IN_DONE] = inDone_q;
		statusWord[ST_ERR] = err_q;
		statusWord[ST_OUT_DONE] = outDone_q;
		// the peripheral side may run on another clock, so only the second flop is read
		pinMeta_d = {periphError, rxValid, rxData};
		pinSync_d = pinMeta_q;
		rxDataS = pinSync_q[7:0];
		rxValidS = pinSync_q[8];
		periphErrorS = pinSync_q[9];
		offset = io.ioAddr - BASE_ADDR;
		// ack_q blocks a second answer while the host still holds the request
		hit = io.ioReq && !ack_q && inSpace(io.ioAddr, SERIAL) &&
			(io.ioAddr >= BASE_ADDR) && (offset < OFS_SPAN);
		pollMine = irqReq_q && io.pollReq && (io.pollLevel == EFF_LEVEL);

		ie_d = ie_q;
		unit_d = unit_q;
		irqReq_d = irqReq_q;
		inDone_d = inDone_q;
		err_d = err_q;
		outDone_d = outDone_q;
		inBuf_d = inBuf_q;
		outBuf_d = outBuf_q;
		txData_d = txData_q;
		txStrobe_d = 1'b0;
		outState_d = outState_q;
		ack_d = 1'b0;
		pollAck_d = 1'b0;
		rdata_d = rdata_q;

		// clears from bus accesses first, so hardware sets below win the same cycle
		if (hit) begin
			ack_d = 1'b1;
			if (isReg(offset, OFS_STATUS)) begin
				if (io.ioWr) begin
					ie_d = io.ioWdata[ST_IE];
					unit_d = io.ioWdata[ST_UNIT_LO +: UNIT_W];
					if (io.ioWdata[ST_FUNC] && outState_q == OUT_IDLE) begin
						outDone_d = 1'b0;
						outState_d = OUT_BUSY;
					end
				end else begin
					rdata_d = io.ioByte ? {8'h00, statusWord[7:0]} : statusWord;
					irqReq_d = 1'b0;
				end
			end else if (isReg(offset, OFS_INBUF)) begin
				if (!io.ioWr) begin
					rdata_d = {8'h00, inBuf_q};
					inDone_d = 1'b0;
					err_d = 1'b0;
				end
			end else if (isReg(offset, OFS_OUTBUF)) begin
				if (io.ioWr) begin
					outBuf_d = io.ioWdata[7:0];
					outDone_d = 1'b0;
					outState_d = OUT_BUSY;
				end else begin
					rdata_d = {8'h00, outBuf_q};
				end
			end
		end

		if (pollMine && io.pollChainIn && !pollAck_q) begin
			pollAck_d = 1'b1;
			rdata_d = VECTOR;
		end

		case (outState_q)
			OUT_IDLE: begin
			end
			OUT_BUSY: begin
				if (tick) begin
					txData_d = outBuf_q;
					txStrobe_d = 1'b1;
					outDone_d = 1'b1;
					outState_d = OUT_IDLE;
				end
			end
			default: begin
				outState_d = OUT_IDLE;
			end
		endcase

		if (rxValidS) begin
			if (inDone_q) begin
				err_d = 1'b1;
			end else begin
				inBuf_d = rxDataS;
				inDone_d = 1'b1;
			end
		end
		if (periphErrorS) begin
			err_d = 1'b1;
		end

		flagsNow = {outDone_q, err_q, inDone_q};
		rise = flagsNow & ~flagsPrev_q;
		flagsPrev_d = flagsNow;
		if (ie_q && |rise) begin
			irqReq_d = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ie_q <= 1'b0;
			unit_q <= '0;
			irqReq_q <= 1'b0;
			inDone_q <= 1'b0;
			err_q <= 1'b0;
			outDone_q <= 1'b1;
			inBuf_q <= '0;
			outBuf_q <= '0;
			txData_q <= '0;
			txStrobe_q <= 1'b0;
			flagsPrev_q <= 3'h4;
			outState_q <= OUT_IDLE;
			ack_q <= 1'b0;
			pollAck_q <= 1'b0;
			rdata_q <= '0;
			pinMeta_q <= '0;
			pinSync_q <= '0;
		end else begin
			ie_q <= ie_d;
			unit_q <= unit_d;
			irqReq_q <= irqReq_d;
			inDone_q <= inDone_d;
			err_q <= err_d;
			outDone_q <= outDone_d;
			inBuf_q <= inBuf_d;
			outBuf_q <= outBuf_d;
			txData_q <= txData_d;
			txStrobe_q <= txStrobe_d;
			flagsPrev_q <= flagsPrev_d;
			outState_q <= outState_d;
			ack_q <= ack_d;
			pollAck_q <= pollAck_d;
			rdata_q <= rdata_d;
			pinMeta_q <= pinMeta_d;
			pinSync_q <= pinSync_d;
		end
	end

	assign io.ioAck = ack_q;
	assign io.pollAck = pollAck_q;
	assign io.ioRdata = rdata_q;
	assign io.reqLevel = irqReq_q ? (NUM_LEVELS'(1) << EFF_LEVEL) : '0;
	// a requester on this level swallows the grant so lower ones stay silent
	assign io.pollChainOut = io.pollChainIn && !pollMine;
	assign txData = txData_q;
	assign txStrobe = txStrobe_q;
	assign unitSel = unit_q;
	assign irqPending = irqReq_q;
endmodule

// >>> psii_host.sv
`timescale 1ns/1ps
module psii_host
	import psii_pkg::*;
#(
	parameter int NOACK_LIMIT = NOACK_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	psii_io_if.host io
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b001,
		H_XFER = 3'b010,
		H_POLL = 3'b100
	} psii_hstate_t;
	localparam int WW = $clog2(NOACK_LIMIT + 1);

	psii_hstate_t st_q, st_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic wr_q, wr_d;
	logic byte_q, byte_d;
	logic [DATA_W-1:0] wdata_q, wdata_d;
	logic [DATA_W-1:0] result_q, result_d;
	logic noAck_q, noAck_d;
	logic [DATA_W-1:0] vector_q, vector_d;
	logic [1:0] pollLvl_q, pollLvl_d;
	logic autoPoll_q, autoPoll_d;
	logic [NUM_EV-1:0] ev_q, ev_d;
	logic [NUM_EV-1:0] en_q, en_d;
	logic [WW-1:0] wait_q, wait_d;
	logic [31:0] prdata_q, prdata_d;
	logic perr_q, perr_d;
	logic setup;
	logic access;
	logic [1:0] topLevel;

	function automatic logic [1:0] highestLevel(input logic [NUM_LEVELS-1:0] lv);
		logic [1:0] r;
		r = '0;
		for (int i = 0; i < NUM_LEVELS; i++) begin
			if (lv[i]) begin
				r = 2'(i);
			end
		end
		return r;
	endfunction

	always_comb begin
		setup = psel && !penable;
		access = psel && penable;
		topLevel = highestLevel(io.reqLevel);
		st_d = st_q;
		addr_d = addr_q;
		wr_d = wr_q;
		byte_d = byte_q;
		wdata_d = wdata_q;
		result_d = result_q;
		noAck_d = noAck_q;
		vector_d = vector_q;
		pollLvl_d = pollLvl_q;
		autoPoll_d = autoPoll_q;
		ev_d = ev_q;
		en_d = en_q;
		wait_d = wait_q;
		prdata_d = prdata_q;
		perr_d = 1'b0;

		if (setup) begin
			prdata_d = '0;
			if (paddr == APB_CMD) begin
				prdata_d = {14'h0, byte_q, wr_q, addr_q};
			end else if (paddr == APB_WDATA) begin
				prdata_d = {16'h0, wdata_q};
			end else if (paddr == APB_RESULT) begin
				prdata_d = {14'h0, noAck_q, st_q != H_IDLE, result_q};
			end else if (paddr == APB_IRQ_STATUS) begin
				prdata_d = 32'(ev_q);
			end else if (paddr == APB_IRQ_ENABLE) begin
				prdata_d = 32'(en_q);
			end else if (paddr == APB_VECTOR) begin
				prdata_d = {14'h0, pollLvl_q, vector_q};
			end else if (paddr == APB_POLL_CTRL) begin
				prdata_d = {31'h0, autoPoll_q};
			end else if (paddr != APB_IRQ_CLEAR) begin
				perr_d = 1'b1;
			end
		end else if (access) begin
			perr_d = perr_q;
		end

		if (access && pwrite) begin
			if (paddr == APB_CMD) begin
				// a command written while the bus is busy is dropped
				if (st_q == H_IDLE) begin
					addr_d = pwdata[ADDR_W-1:0];
					wr_d = pwdata[CMD_WR];
					byte_d = pwdata[CMD_BYTE];
					st_d = H_XFER;
					wait_d = '0;
				end
			end else if (paddr == APB_WDATA) begin
				wdata_d = pwdata[DATA_W-1:0];
			end else if (paddr == APB_IRQ_CLEAR) begin
				ev_d = ev_q & ~pwdata[NUM_EV-1:0];
			end else if (paddr == APB_IRQ_ENABLE) begin
				en_d = pwdata[NUM_EV-1:0];
			end else if (paddr == APB_POLL_CTRL) begin
				autoPoll_d = pwdata[0];
			end
		end

		case (st_q)
			H_IDLE: begin
				// no new poll while a vector event is pending, so software must clear it to allow the next
				if (st_d == H_IDLE && autoPoll_q && |io.reqLevel && !ev_q[EV_VECTOR]) begin
					pollLvl_d = topLevel;
					st_d = H_POLL;
					wait_d = '0;
				end
			end
			H_XFER: begin
				wait_d = wait_q + WW'(1);
				if (io.ioAck) begin
					result_d = io.ioRdata;
					noAck_d = 1'b0;
					ev_d[EV_XFER] = 1'b1;
					st_d = H_IDLE;
				end else if (wait_q == WW'(NOACK_LIMIT)) begin
					noAck_d = 1'b1;
					ev_d[EV_XFER] = 1'b1;
					st_d = H_IDLE;
				end
			end
			H_POLL: begin
				wait_d = wait_q + WW'(1);
				if (io.pollAck) begin
					vector_d = io.ioRdata;
					ev_d[EV_VECTOR] = 1'b1;
					st_d = H_IDLE;
				end else if (wait_q == WW'(NOACK_LIMIT)) begin
					st_d = H_IDLE;
				end
			end
			default: begin
				st_d = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st_q <= H_IDLE;
			addr_q <= '0;
			wr_q <= 1'b0;
			byte_q <= 1'b0;
			wdata_q <= '0;
			result_q <= '0;
			noAck_q <= 1'b0;
			vector_q <= '0;
			pollLvl_q <= '0;
			autoPoll_q <= 1'b0;
			ev_q <= '0;
			en_q <= '0;
			wait_q <= '0;
			prdata_q <= '0;
			perr_q <= 1'b0;
		end else begin
			st_q <= st_d;
			addr_q <= addr_d;
			wr_q <= wr_d;
			byte_q <= byte_d;
			wdata_q <= wdata_d;
			result_q <= result_d;
			noAck_q <= noAck_d;
			vector_q <= vector_d;
			pollLvl_q <= pollLvl_d;
			autoPoll_q <= autoPoll_d;
			ev_q <= ev_d;
			en_q <= en_d;
			wait_q <= wait_d;
			prdata_q <= prdata_d;
			perr_q <= perr_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = access && perr_q;
	assign irq = |(ev_q & en_q);
	assign io.ioReq = (st_q == H_XFER);
	assign io.ioWr = wr_q;
	assign io.ioByte = byte_q;
	assign io.ioAddr = addr_q;
	assign io.ioWdata = wdata_q;
	assign io.pollReq = (st_q == H_POLL);
	assign io.pollLevel = pollLvl_q;
endmodule

// >>> psii_properties.sv
`timescale 1ns/1ps
module psii_properties
	import psii_pkg::*;
#(
	parameter logic [ADDR_W-1:0] BASE_ADDR = 16'hFFF0,
	parameter logic [DATA_W-1:0] VECTOR = 16'h0040
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic ioReq,
	input wire logic ioWr,
	input wire logic [ADDR_W-1:0] ioAddr,
	input wire logic [DATA_W-1:0] ioRdata,
	input wire logic ioAck,
	input wire logic [NUM_LEVELS-1:0] reqLevel,
	input wire logic pollReq,
	input wire logic pollAck,
	input wire logic pollChainIn,
	input wire logic pollChainOut
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	logic hit;
	assign hit = ioAddr >= BASE_ADDR && ioAddr < BASE_ADDR + OFS_SPAN;
	sequence s_ioStart;
		$rose(ioReq) && hit;
	endsequence
	// a poll that starts while we request level 0 with the grant present must be answered
	sequence s_pollOwn;
		$rose(pollReq) && reqLevel[0] && pollChainIn;
	endsequence
	a_ack_next: assert property (s_ioStart |=> ioAck)
		else $error("own address not answered one cycle later");
	a_ack_pulse: assert property (ioAck |=> !ioAck)
		else $error("answer held longer than one cycle");
	a_no_foreign: assert property (ioReq && !hit |=> !ioAck)
		else $error("answer given outside the register window");
	a_serial_level: assert property (reqLevel[NUM_LEVELS-1:1] == 3'h0)
		else $error("serial device raised a parallel level");
	a_poll_answer: assert property (s_pollOwn |=> pollAck)
		else $error("pending request did not answer its poll");
	a_poll_silent: assert property ($rose(pollReq) && !pollChainIn |=> !pollAck)
		else $error("poll answered without the grant");
	a_vec_wired: assert property (pollAck |-> ioRdata == VECTOR)
		else $error("poll answer is not the wired vector");
	a_chain_block: assert property (pollReq && reqLevel[0] && pollChainIn |-> !pollChainOut)
		else $error("grant passed on by a requesting device");
	a_chain_pass: assert property (!pollReq |-> pollChainOut == pollChainIn)
		else $error("grant blocked while no poll runs");
	a_read_clears: assert property (ioAck && !ioWr && ioAddr == BASE_ADDR |=> !reqLevel[0])
		else $error("status read left the request standing");
endmodule

// >>> tb_peripheral_status_irq_interface.sv
`timescale 1ns/1ps
module tb_peripheral_status_irq_interface
	import psii_pkg::*;
;
	typedef struct {
		logic [7:0] gap;
		logic [9:0] rx;
		logic [1:0] bw;
		logic [15:0] addr;
		logic [15:0] wd;
		logic [17:0] expv;
		logic [17:0] mask;
	} psii_row_t;
	localparam int CP = 40;
	localparam logic [15:0] VEC = 16'h00A4;
	localparam logic [15:0] ST = 16'hFFF0;
	localparam logic [15:0] IB = 16'hFFF2;
	localparam logic [15:0] OB = 16'hFFF4;
	localparam logic [7:0] G = 8'h3C;
	localparam logic [17:0] M = 18'h3FFFF;
	localparam logic [17:0] A = 18'h30000;
	localparam logic [17:0] N = 18'h00000;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, r;
	logic pready, pslverr, irq, txStrobe, irqPending, e;
	logic rxValid = 1'b0, periphError = 1'b0, pollChainIn = 1'b0;
	logic [7:0] rxData = 8'h00, txData, lastTx;
	logic [1:0] unitSel;
	int num_errors = 0, tests_run = 0, txCount = 0, cyc = 0;
	// gap 0 after an output write catches the done flag still low
	psii_row_t rows [22] = '{
		'{G, 10'h000, 2'h0, ST, 16'h0000, 18'h00080, M}, '{G, 10'h000, 2'h1, ST, 16'h000D, N, N},
		'{G, 10'h000, 2'h0, ST, 16'h0000, 18'h0008D, M}, '{G, 10'h000, 2'h3, OB, 16'h0041, N, N},
		'{8'h00, 10'h000, 2'h0, ST, 16'h0000, 18'h0000D, M},
		'{G, 10'h000, 2'h0, ST, 16'h0000, 18'h0009D, M}, '{G, 10'h000, 2'h2, ST, 16'h0000, 18'h0008D, M},
		'{G, 10'h15A, 2'h0, ST, 16'h0000, 18'h000BD, M}, '{G, 10'h1A5, 2'h0, ST, 16'h0000, 18'h000FD, M},
		'{G, 10'h000, 2'h2, IB, 16'h0000, 18'h0005A, M}, '{G, 10'h000, 2'h0, ST, 16'h0000, 18'h0008D, M},
		'{G, 10'h200, 2'h0, ST, 16'h0000, 18'h000DD, M}, '{G, 10'h000, 2'h2, IB, 16'h0000, N, N},
		'{G, 10'h000, 2'h0, ST, 16'h0000, 18'h0008D, M}, '{G, 10'h000, 2'h0, 16'hFFE0, 16'h0000, 18'h20000, A},
		'{G, 10'h000, 2'h0, 16'hFE00, 16'h0000, 18'h20000, A}, '{G, 10'h000, 2'h1, ST, 16'h0003, N, N},
		'{G, 10'h000, 2'h0, ST, 16'h0000, 18'h00091, M}, '{G, 10'h000, 2'h1, ST, 16'h0000, N, N},
		'{G, 10'h000, 2'h3, OB, 16'h0042, N, N}, '{G, 10'h000, 2'h0, ST, 16'h0000, 18'h00080, M},
		'{G, 10'h000, 2'h2, OB, 16'h0000, 18'h00042, M}
	};
	psii_io_if i_psii_io_if (.clock(clock), .pollChainIn(pollChainIn));
	psii_host #(.NOACK_LIMIT(8)) i_psii_host (.clock(clock), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .io(i_psii_io_if.host));
	psii_device #(.CHAR_PERIOD(CP), .VECTOR(VEC)) i_psii_device (.clock(clock), .rst(rst),
		.io(i_psii_io_if.dev), .txData(txData), .txStrobe(txStrobe), .rxValid(rxValid),
		.rxData(rxData), .periphError(periphError), .unitSel(unitSel), .irqPending(irqPending));
	psii_properties #(.VECTOR(VEC)) i_psii_properties (.clock(clock), .rst(rst),
		.ioReq(i_psii_io_if.ioReq), .ioWr(i_psii_io_if.ioWr), .ioAddr(i_psii_io_if.ioAddr),
		.ioRdata(i_psii_io_if.ioRdata), .ioAck(i_psii_io_if.ioAck),
		.reqLevel(i_psii_io_if.reqLevel), .pollReq(i_psii_io_if.pollReq),
		.pollAck(i_psii_io_if.pollAck), .pollChainIn(pollChainIn),
		.pollChainOut(i_psii_io_if.pollChainOut));
	task automatic close_out();
		$display("errors=%0d checks=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
		tests_run++;
		if (seen !== expv) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic ioOp(input psii_row_t w);
		repeat (w.gap) @(posedge clock);
		rxData <= w.rx[7:0];
		rxValid <= w.rx[8];
		periphError <= w.rx[9];
		@(posedge clock);
		rxValid <= 1'b0;
		periphError <= 1'b0;
		apb(1'b1, APB_WDATA, {16'h0000, w.wd});
		apb(1'b1, APB_CMD, {14'h0000, w.bw, w.addr});
		do apb(1'b0, APB_RESULT, 32'h00000000); while (r[RES_BUSY] !== 1'b0);
	endtask
	always #2.5 clock = ~clock;
	// falling edge keeps the strobe sample clear of the register update
	always @(negedge clock) begin
		if (txStrobe === 1'b1) begin
			txCount <= txCount + 1;
			lastTx <= txData;
		end
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			close_out();
		end
	end
	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		apb(1'b0, APB_RESULT, 32'h00000000);
		chk(r, 32'h00000000);
		foreach (rows[i]) begin
			ioOp(rows[i]);
			chk(32'(r[17:0] & rows[i].mask), 32'(rows[i].expv & rows[i].mask));
		end
		chk(32'(txCount), 32'h00000003);
		chk({24'h000000, lastTx}, 32'h00000042);
		apb(1'b0, APB_CMD, 32'h00000000);
		chk(r, {14'h0000, 2'h2, OB});
		apb(1'b0, APB_IRQ_STATUS, 32'h00000000);
		chk(r, 32'h00000001);
		apb(1'b1, APB_IRQ_ENABLE, 32'h00000001);
		@(negedge clock);
		chk({31'h00000000, irq}, 32'h00000001);
		apb(1'b1, APB_IRQ_ENABLE, 32'h00000000);
		@(negedge clock);
		chk({31'h00000000, irq}, 32'h00000000);
		apb(1'b1, APB_IRQ_CLEAR, 32'h00000003);
		apb(1'b0, APB_IRQ_STATUS, 32'h00000000);
		chk(r, 32'h00000000);
		apb(1'b0, 12'h020, 32'h00000000);
		chk({r[30:0], e}, 32'h00000001);
		ioOp('{8'h00, 10'h000, 2'h1, ST, 16'h0005, N, N});
		chk({30'h00000000, unitSel}, 32'h00000001);
		ioOp('{8'h00, 10'h177, 2'h2, IB, 16'h0000, N, N});
		chk({31'h00000000, irqPending}, 32'h00000001);
		apb(1'b1, APB_POLL_CTRL, 32'h00000001);
		apb(1'b0, APB_POLL_CTRL, 32'h00000000);
		chk(r, 32'h00000001);
		repeat (30) @(posedge clock);
		apb(1'b0, APB_IRQ_STATUS, 32'h00000000);
		chk(r & 32'h00000002, 32'h00000000);
		pollChainIn <= 1'b1;
		repeat (30) @(posedge clock);
		apb(1'b0, APB_IRQ_STATUS, 32'h00000000);
		chk(r & 32'h00000002, 32'h00000002);
		apb(1'b0, APB_VECTOR, 32'h00000000);
		chk(r, {16'h0000, VEC});
		ioOp('{8'h00, 10'h000, 2'h0, ST, 16'h0000, N, N});
		chk(32'(r[17:0]), 32'h00000095);
		chk({31'h00000000, irqPending}, 32'h00000000);
		rst <= 1'b1;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		ioOp('{8'h00, 10'h000, 2'h0, ST, 16'h0000, N, N});
		chk(32'(r[17:0]), 32'h00000080);
		close_out();
	end
endmodule
